//--- design/omc_pkg.sv
// Package for the oscillator and operating-mode control block
package omc_pkg;
	// Register word offsets (byte addresses)
	localparam logic [3:0] OMC_SCC_OFF      = 4'h0;
	localparam logic [3:0] OMC_RC_OFF       = 4'h4;
	localparam logic [3:0] OMC_HXT_OFF      = 4'h8;
	localparam logic [3:0] OMC_LXT_OFF      = 4'hc;
	localparam logic [3:0] OMC_STATUS_OFF   = 4'h0;
	localparam logic [7:0] OMC_STATUS_ADDR  = 8'h10;
	// Reset values
	localparam logic [7:0] OMC_SCC_RST      = 8'h00;
	localparam logic [1:0] OMC_RC_SEL_RST   = 2'h0;
	localparam logic       OMC_RC_EN_RST    = 1'b1;
	// Field positions in the system clock control register
	localparam int OMC_CKS_LSB  = 5;
	localparam int OMC_FHS_BIT  = 3;
	localparam int OMC_FSS_BIT  = 2;
	localparam int OMC_FHK_BIT  = 1;
	localparam int OMC_FSK_BIT  = 0;
	localparam logic [2:0] OMC_CKS_SLOW = 3'h7;
	// Divider counter width: divide by up to 64
	localparam int OMC_DIV_W    = 6;
	// Stabilisation times in microseconds, converted to 250 MHz cycles
	localparam int OMC_CLK_MHZ      = 250;
	localparam int OMC_RC_STAB_US   = 16;
	localparam int OMC_HXT_STAB_US  = 8;
	localparam int OMC_LXT_FAST_US  = 10;
	localparam int OMC_LXT_SLOW_US  = 14;
	localparam logic [15:0] OMC_RC_STAB_CYC  = 16'(OMC_RC_STAB_US * OMC_CLK_MHZ);
	localparam logic [15:0] OMC_HXT_STAB_CYC = 16'(OMC_HXT_STAB_US * OMC_CLK_MHZ);
	localparam logic [15:0] OMC_LXT_FAST_CYC = 16'(OMC_LXT_FAST_US * OMC_CLK_MHZ);
	localparam logic [15:0] OMC_LXT_SLOW_CYC = 16'(OMC_LXT_SLOW_US * OMC_CLK_MHZ);

	typedef enum {OMC_RUN, OMC_SLEEP, OMC_IDLE_LO, OMC_IDLE_BOTH, OMC_IDLE_HI} omc_mode_t;

	// Clock enables handed to the rest of the chip
	typedef struct packed {
		logic sys;
		logic fast;
		logic slow;
		logic internal_slow_rc;
	} omc_clk_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} omc_wb_req_t;
endpackage

//--- design/omc_top.sv
// Oscillator control, system clock selection and halt mode decode
// Contract
// - RC frequency select 00/11 gives 8 MHz, 01 gives 12, 10 gives 16
// - New RC frequency is applied only after the RC stable flag is 1
// - Enabling RC or changing its select clears stable flag, then sets it when stable
// - RC enable bit is read-write, 1 enables, powers up as 1
// - Enabling fast crystal clears its stable flag, then sets it when stable
// - Slow crystal speed-up bit selects quick start or low power
// - Speed-up bit is frozen while slow crystal is the system clock
// - Enabling slow crystal clears its stable flag, then sets it when stable
// - Slow crystal enable bit is read-write, powers up as 0
// - Unused upper bits of oscillator control registers read zero
// - Clock select 111 moves system clock to the slow clock
// - Slow mode uses chosen slow source and switches only once it is stable
// - Clock select 000 to 110 gives fast clock divided by 1 to 64
// - Halt with both keep-on bits 0 enters sleep, stopping all but watchdog
// - Halt with fast 0, slow 1 enters idle with slow clock only
// - Halt with both keep-on bits 1 enters idle with both clocks
// - Halt with fast 1, slow 0 enters idle with fast clock only
// - Entering any halt mode sets power-down, clears timeout, restarts watchdog; a timeout in the halt cycle sets the flag instead
// - High source select picks RC at 0, fast crystal at 1
`timescale 1ns/1ps
module omc_top
	import omc_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire omc_pkg::omc_wb_req_t wb_req_i,
	output logic [31:0]          wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            halt_i,
	input  wire logic            wake_i,
	input  wire logic            wdt_timeout_i,
	output omc_pkg::omc_clk_t    clk_en_o,
	output logic [7:0]           rc_freq_mhz_o,
	output logic                 power_down_flag_o,
	output logic                 watchdog_timeout_flag_o,
	output logic                 wdt_clear_o
);
	import omc_pkg::*;

	logic [7:0]      system_clock_ctrl;
	logic [1:0]      rc_freq_select;
	logic            rc_osc_enable;
	logic            rc_stable_flag;
	logic            fast_crystal_range;
	logic            fast_crystal_enable;
	logic            fast_crystal_stable;
	logic            slow_crystal_speedup;
	logic            slow_crystal_enable;
	logic            slow_crystal_stable;
	logic [15:0]     rc_cnt;
	logic [15:0]     hxt_cnt;
	logic [15:0]     lxt_cnt;
	logic [2:0]      cks_active;
	logic            slow_active;
	logic [OMC_DIV_W-1:0] div_cnt;
	logic            sys_tick;
	omc_mode_t       mode;
	logic            wr_stb;
	logic [7:0]      wr_byte;
	logic [2:0]      cks_req;
	logic            fast_ok;
	logic            slow_ok;
	logic            lxt_is_sys;
	logic            bus_take;
	logic            scc_wr;
	logic            rc_wr;
	logic            hxt_wr;
	logic            lxt_wr;
	logic            rc_restart;
	logic            halt_take;
	logic            fast_on;
	logic            slow_on;

	function automatic logic [7:0] rc_mhz(input logic [1:0] code);
		case (code)
			2'b01:   rc_mhz = 8'h0c;
			2'b10:   rc_mhz = 8'h10;
			default: rc_mhz = 8'h08;
		endcase
	endfunction

	function automatic logic [OMC_DIV_W-1:0] div_mask(input logic [2:0] cks);
		div_mask = OMC_DIV_W'((7'h01 << cks) - 7'h01);
	endfunction

	// Register word hit on the byte address
	function automatic logic reg_hit(input logic [7:0] adr, input logic [3:0] off);
		reg_hit = adr == {4'h0, off};
	endfunction

	// Stabilisation count reached; limits are at least one cycle
	function automatic logic cnt_done(input logic [15:0] cnt, input logic [15:0] lim);
		cnt_done = cnt >= lim - 16'h0001;
	endfunction

	// Bus decode; writes use byte lane 0 only
	assign bus_take   = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
	assign wr_stb     = bus_take && wb_req_i.we && wb_req_i.sel[0];
	assign wr_byte    = wb_req_i.dat[7:0];
	assign scc_wr     = wr_stb && reg_hit(wb_req_i.adr, OMC_SCC_OFF);
	assign rc_wr      = wr_stb && reg_hit(wb_req_i.adr, OMC_RC_OFF);
	assign hxt_wr     = wr_stb && reg_hit(wb_req_i.adr, OMC_HXT_OFF);
	assign lxt_wr     = wr_stb && reg_hit(wb_req_i.adr, OMC_LXT_OFF);
	// Disable, enable or a new select restarts the count, so a stale frequency never shows
	assign rc_restart = rc_wr && (wr_byte[0] != rc_osc_enable || wr_byte[3:2] != rc_freq_select);
	// Clock switch request and readiness of the chosen sources
	assign cks_req    = system_clock_ctrl[7:OMC_CKS_LSB];
	assign fast_ok    = system_clock_ctrl[OMC_FHS_BIT] ? fast_crystal_stable : rc_stable_flag;
	assign slow_ok    = system_clock_ctrl[OMC_FSS_BIT] ? slow_crystal_stable : 1'b1;
	assign lxt_is_sys = slow_active && system_clock_ctrl[OMC_FSS_BIT];
	// Halt counts only from run; a halt pulse while halted is ignored
	assign halt_take  = (mode == OMC_RUN) && halt_i;
	// Oscillator gates: each clock is kept in idle only by its own keep-on bit
	assign fast_on    = mode == OMC_RUN || mode == OMC_IDLE_BOTH || mode == OMC_IDLE_HI;
	assign slow_on    = mode == OMC_RUN || mode == OMC_IDLE_BOTH || mode == OMC_IDLE_LO;

	// Bus slave: one wait-free ack, dropped the cycle after it is given
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_take;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (bus_take)
			case (wb_req_i.adr)
				{4'h0, OMC_SCC_OFF}: wb_dat_o <= {24'h00_0000, system_clock_ctrl[7:5], 1'b0, system_clock_ctrl[3:0]};
				{4'h0, OMC_RC_OFF}:  wb_dat_o <= {28'h000_0000, rc_freq_select, rc_stable_flag, rc_osc_enable};
				{4'h0, OMC_HXT_OFF}: wb_dat_o <= {29'h0000_0000, fast_crystal_range, fast_crystal_stable,
					fast_crystal_enable};
				{4'h0, OMC_LXT_OFF}: wb_dat_o <= {29'h0000_0000, slow_crystal_speedup, slow_crystal_stable,
					slow_crystal_enable};
				OMC_STATUS_ADDR:     wb_dat_o <= {24'h00_0000, 1'b0, slow_active, cks_active, power_down_flag_o,
					watchdog_timeout_flag_o, mode != OMC_RUN};
				default:             wb_dat_o <= 32'h0000_0000;
			endcase
	end

	// System clock control register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			system_clock_ctrl <= OMC_SCC_RST;
		else if (scc_wr)
			system_clock_ctrl <= {wr_byte[7:5], 1'b0, wr_byte[3:0]};
	end

	// Internal RC: enable, select and stable flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rc_osc_enable  <= OMC_RC_EN_RST;
			rc_freq_select <= OMC_RC_SEL_RST;
		end
		else if (rc_wr)
		begin
			rc_osc_enable  <= wr_byte[0];
			rc_freq_select <= wr_byte[3:2];
		end
	end

	// Restart on any enable or select change; power-up counts as an enable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rc_cnt         <= 16'h0000;
			rc_stable_flag <= 1'b0;
		end
		else if (rc_restart)
		begin
			rc_cnt         <= 16'h0000;
			rc_stable_flag <= 1'b0;
		end
		else if (!rc_osc_enable)
		begin
			rc_cnt         <= 16'h0000;
			rc_stable_flag <= 1'b0;
		end
		else if (cnt_done(rc_cnt, OMC_RC_STAB_CYC))
			rc_stable_flag <= 1'b1;
		else
			rc_cnt <= rc_cnt + 16'h0001;
	end

	// Output follows the select only while stable, so a change always passes through 0
	// No extra stage: the select is settled before the flag can rise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rc_freq_mhz_o <= 8'h00;
		else
			rc_freq_mhz_o <= rc_stable_flag ? rc_mhz(rc_freq_select) : 8'h00;
	end

	// Fast crystal; range bit is ignored while enabled
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fast_crystal_enable <= 1'b0;
			fast_crystal_range  <= 1'b0;
		end
		else if (hxt_wr)
		begin
			fast_crystal_enable <= wr_byte[0];
			if (!fast_crystal_enable)
				fast_crystal_range <= wr_byte[2];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hxt_cnt             <= 16'h0000;
			fast_crystal_stable <= 1'b0;
		end
		else if (!fast_crystal_enable)
		begin
			hxt_cnt             <= 16'h0000;
			fast_crystal_stable <= 1'b0;
		end
		else if (cnt_done(hxt_cnt, OMC_HXT_STAB_CYC))
			fast_crystal_stable <= 1'b1;
		else
			hxt_cnt <= hxt_cnt + 16'h0001;
	end

	// Slow crystal; speed-up frozen while it drives the system clock
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			slow_crystal_enable  <= 1'b0;
			slow_crystal_speedup <= 1'b0;
		end
		else if (lxt_wr)
		begin
			slow_crystal_enable <= wr_byte[0];
			if (!lxt_is_sys)
				slow_crystal_speedup <= wr_byte[2];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lxt_cnt             <= 16'h0000;
			slow_crystal_stable <= 1'b0;
		end
		else if (!slow_crystal_enable)
		begin
			lxt_cnt             <= 16'h0000;
			slow_crystal_stable <= 1'b0;
		end
		else if (cnt_done(lxt_cnt, slow_crystal_speedup ? OMC_LXT_FAST_CYC : OMC_LXT_SLOW_CYC))
			slow_crystal_stable <= 1'b1;
		else
			lxt_cnt <= lxt_cnt + 16'h0001;
	end

	// Source and ratio switch at a divider wrap, or at once when leaving slow mode, so no short pulse is made
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cks_active  <= 3'h0;
			slow_active <= 1'b0;
		end
		else if (cks_req == OMC_CKS_SLOW)
		begin
			if (slow_ok && (slow_active || sys_tick))
				slow_active <= 1'b1;
		end
		else if (fast_ok && (sys_tick || slow_active))
		begin
			slow_active <= 1'b0;
			cks_active  <= cks_req;
		end
	end

	// Divider: tick once per 2**cks fast cycles
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_cnt  <= '0;
			sys_tick <= 1'b0;
		end
		else if (div_cnt >= div_mask(cks_active))
		begin
			div_cnt  <= '0;
			sys_tick <= 1'b1;
		end
		else
		begin
			div_cnt  <= div_cnt + OMC_DIV_W'(1);
			sys_tick <= 1'b0;
		end
	end

	// Halt mode decode; wake returns to run
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode <= OMC_RUN;
		else
			case (mode)
				OMC_RUN:
					if (halt_i)
						case (system_clock_ctrl[OMC_FHK_BIT:OMC_FSK_BIT])
							2'b00:   mode <= OMC_SLEEP;
							2'b01:   mode <= OMC_IDLE_LO;
							2'b11:   mode <= OMC_IDLE_BOTH;
							default: mode <= OMC_IDLE_HI;
						endcase
				default:
					if (wake_i)
						mode <= OMC_RUN;
			endcase
	end

	// Power-down and timeout flags, watchdog restart pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			power_down_flag_o       <= 1'b0;
			watchdog_timeout_flag_o <= 1'b0;
			wdt_clear_o             <= 1'b0;
		end
		else
		begin
			wdt_clear_o <= halt_take;
			if (halt_take)
				power_down_flag_o <= 1'b1;
			// A timeout in the halt cycle wins over the clear, so it is never lost
			if (wdt_timeout_i)
				watchdog_timeout_flag_o <= 1'b1;
			else if (halt_take)
				watchdog_timeout_flag_o <= 1'b0;
		end
	end

	// Clock gates; slow clock off in sleep and fast-only idle, all off except watchdog in sleep
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clk_en_o <= '0;
		else
		begin
			clk_en_o.internal_slow_rc <= 1'b1;
			clk_en_o.fast <= fast_on && fast_ok;
			clk_en_o.slow <= slow_on && slow_ok;
			clk_en_o.sys  <= (mode == OMC_RUN) && (slow_active ? 1'b1 : sys_tick);
		end
	end
endmodule

//--- verif/omc_checker.sv
// Assertion checker for the oscillator and mode control block
`timescale 1ns/1ps
module omc_checker
	import omc_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire omc_pkg::omc_wb_req_t wb_req_i,
	input  wire logic                 wb_ack_o,
	input  wire logic                 halt_i,
	input  wire logic                 wdt_timeout_i,
	input  wire logic [7:0]           rc_freq_mhz_o,
	input  wire logic                 power_down_flag_o,
	input  wire logic                 watchdog_timeout_flag_o,
	input  wire logic                 wdt_clear_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_after_req: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_rc_freq_legal: assert property (rc_freq_mhz_o inside {8'h00, 8'h08, 8'h0c, 8'h10})
		else $error("bad rc frequency");
	a_rc_via_zero: assert property ($changed(rc_freq_mhz_o) && rc_freq_mhz_o != 8'h00 |-> $past(rc_freq_mhz_o) == 8'h00)
		else $error("rc frequency switched while stable");
	a_halt_sets_pd: assert property (halt_i |=> power_down_flag_o)
		else $error("power down flag not set");
	a_halt_clears_to: assert property (halt_i && !wdt_timeout_i |=> !watchdog_timeout_flag_o)
		else $error("timeout flag not cleared");
	a_pd_sticky: assert property (power_down_flag_o |=> power_down_flag_o)
		else $error("power down flag lost");
	a_wdt_clr_cause: assert property ($rose(wdt_clear_o) |-> $past(halt_i) ##1 !wdt_clear_o)
		else $error("watchdog clear without halt");
	a_timeout_sets: assert property (wdt_timeout_i |=> watchdog_timeout_flag_o)
		else $error("timeout flag not set");
	c_halt: cover property (halt_i);
	c_read: cover property (wb_ack_o && !wb_req_i.we);
	c_rc16: cover property (rc_freq_mhz_o == 8'h10);
endmodule

bind omc_top omc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
	.halt_i(halt_i), .wdt_timeout_i(wdt_timeout_i), .rc_freq_mhz_o(rc_freq_mhz_o),
	.power_down_flag_o(power_down_flag_o), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
	.wdt_clear_o(wdt_clear_o));

//--- verif/omc_top_tb.sv
// Self-checking bench for the oscillator and mode control block
`timescale 1ns/1ps
module omc_top_tb;
	import omc_pkg::*;
	logic        clk_i;
	logic        rst_i;
	omc_wb_req_t req;
	logic [31:0] dat;
	logic        ack;
	logic        halt;
	logic        wake;
	logic        wto;
	omc_clk_t    cen;
	logic [7:0]  freq;
	logic        power_down_flag;
	logic        tof;
	logic        wclr;
	logic [7:0]  rd;
	logic [7:0]  mhz [4];
	int          fails;
	int          cmp_count;
	int          n;

	omc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack), .halt_i(halt),
		.wake_i(wake), .wdt_timeout_i(wto), .clk_en_o(cen), .rc_freq_mhz_o(freq),
		.power_down_flag_o(power_down_flag), .watchdog_timeout_flag_o(tof), .wdt_clear_o(wclr));

	initial
	begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic end_of_test();
		$display("Checks %0d errors %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Full word read data is compared so upper bits must read zero too
	task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d, input logic [3:0] hi = 4'h0);
		int i;
		@(posedge clk_i);
		req <= '{1'h1, 1'h1, we, {hi, a}, 4'h1, {24'h00_0000, d}};
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (ack !== 1'h1 && i < 50);
		rd = dat[7:0];
		chk("upper", 8'h00, dat[31:24] | dat[23:16] | dat[15:8]);
		req <= '0;
		if (i >= 50)
		begin
			fails++;
			end_of_test();
		end
	endtask

	// Bounded poll: stabilisation runs thousands of cycles
	task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input logic [3:0] hi = 4'h0);
		int i;
		for (i = 0; i < 2000; i++)
		begin
			bus(1'h0, a, 8'h00, hi);
			if ((rd & m) === e)
				break;
		end
		chk("poll", e, rd & m);
		if (i == 2000)
			end_of_test();
	endtask

	task automatic cnt(input int c);
		n = 0;
		repeat (c)
		begin
			@(posedge clk_i);
			n += int'(cen.sys === 1'h1);
		end
	endtask

	initial
	begin
		req = '0;
		halt = 1'h0;
		wake = 1'h0;
		wto = 1'h0;
		rst_i = 1'h1;
		mhz = '{8'h08, 8'h0c, 8'h10, 8'h08};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, OMC_RC_OFF, 8'h00);
		chk("rc", 8'h01, rd);
		bus(1'h0, OMC_HXT_OFF, 8'h00);
		chk("hxt", 8'h00, rd);
		bus(1'h0, OMC_LXT_OFF, 8'h00);
		chk("lxt", 8'h00, rd);
		poll(OMC_RC_OFF, 8'h02, 8'h02);
		chk("freq", 8'h08, freq);
		for (int k = 1; k < 5; k++)
		begin
			bus(1'h1, OMC_RC_OFF, {4'h0, 2'(k % 4), 2'h1});
			bus(1'h0, OMC_RC_OFF, 8'h00);
			chk("rc", {4'h0, 2'(k % 4), 2'h1}, rd);
			chk("freq", 8'h00, freq);
			poll(OMC_RC_OFF, 8'h02, 8'h02);
			chk("freq", mhz[k % 4], freq);
		end
		bus(1'h1, OMC_HXT_OFF, 8'hfc);
		bus(1'h0, OMC_HXT_OFF, 8'h00);
		chk("hxt", 8'h04, rd);
		bus(1'h1, OMC_HXT_OFF, 8'h05);
		bus(1'h0, OMC_HXT_OFF, 8'h00);
		chk("hxt", 8'h05, rd);
		poll(OMC_HXT_OFF, 8'h02, 8'h02);
		bus(1'h1, OMC_HXT_OFF, 8'h01);
		bus(1'h0, OMC_HXT_OFF, 8'h00);
		chk("hxt", 8'h07, rd);
		bus(1'h1, OMC_LXT_OFF, 8'h05);
		poll(OMC_LXT_OFF, 8'h07, 8'h07);
		bus(1'h1, OMC_SCC_OFF, 8'he4);
		poll(OMC_STATUS_OFF, 8'h40, 8'h40, 4'h1);
		cnt(16);
		chk("sys", 8'h10, 8'(n));
		bus(1'h1, OMC_LXT_OFF, 8'h01);
		bus(1'h0, OMC_LXT_OFF, 8'h00);
		chk("lxt", 8'h07, rd);
		poll(OMC_RC_OFF, 8'h02, 8'h02);
		bus(1'h1, OMC_SCC_OFF, 8'h60);
		poll(OMC_STATUS_OFF, 8'h78, 8'h18, 4'h1);
		cnt(64);
		chk("sys", 8'h08, 8'(n));
		bus(1'h1, OMC_HXT_OFF, 8'h04);
		bus(1'h1, OMC_SCC_OFF, 8'h28);
		repeat (20) @(posedge clk_i);
		chk("fast", 8'h00, {7'h00, cen.fast});
		poll(OMC_STATUS_OFF, 8'h78, 8'h18, 4'h1);
		bus(1'h1, OMC_HXT_OFF, 8'h05);
		poll(OMC_STATUS_OFF, 8'h78, 8'h08, 4'h1);
		bus(1'h0, 4'h4, 8'h00, 4'h1);
		chk("unmapped", 8'h00, rd);
		for (int k = 0; k < 4; k++)
		begin
			bus(1'h1, OMC_SCC_OFF, 8'(k));
			wto <= 1'h1;
			@(posedge clk_i);
			wto <= 1'h0;
			halt <= 1'h1;
			#1;
			chk("tof", 8'h01, {7'h00, tof});
			@(posedge clk_i);
			halt <= 1'h0;
			#1;
			chk("tof", 8'h00, {7'h00, tof});
			chk("pdf", 8'h01, {7'h00, power_down_flag});
			chk("wclr", 8'h01, {7'h00, wclr});
			@(posedge clk_i);
			wake <= 1'h1;
			#1;
			chk("clk", {4'h0, 1'h1, 2'(k), 1'h0}, {4'h0, cen.internal_slow_rc, cen.fast, cen.slow, cen.sys});
			@(posedge clk_i);
			wake <= 1'h0;
			repeat (3) @(posedge clk_i);
		end
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, OMC_STATUS_OFF, 8'h00, 4'h1);
		chk("status", 8'h00, rd);
		bus(1'h0, OMC_RC_OFF, 8'h00);
		chk("rc", 8'h01, rd);
		end_of_test();
	end
endmodule
